// ===== core/batch_setpoint_defines.vh
// Offsets, field positions, kind codes and timing for the batch setpoint logic
`ifndef BATCH_SETPOINT_DEFINES_VH
`define BATCH_SETPOINT_DEFINES_VH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_CMD 12'h004
`define REG_STATUS 12'h008
`define REG_OUTS 12'h00C
`define REG_TICK 12'h010
`define CFG_PAGE 4'h1

// Control and command bits
`define CTRL_AUTO_BIT 0
`define CMD_START_BIT 0
`define CMD_ABORT_BIT 1
`define CTRL_RESET 1'b0

// Status fields
`define ST_RUN_BIT 0
`define ST_STEP_LSB 8
`define ST_STEP_MSB 12
`define ST_REP_LSB 16
`define ST_REP_MSB 31

// Setpoint config word
`define CFG_W 30
`define CFG_KIND_LSB 0
`define CFG_KIND_MSB 3
`define CFG_VAL_LSB 4
`define CFG_VAL_MSB 19
`define CFG_START_LSB 20
`define CFG_START_MSB 24
`define CFG_END_LSB 25
`define CFG_END_MSB 29
`define SP_IDX_W 5
`define VAL_W 16

// Setpoint kinds
`define KIND_OFF 4'h0
`define KIND_DELAY 4'h1
`define KIND_STANDSTILL_WAIT_STEP 4'h2
`define KIND_REPEAT 4'h3
`define KIND_FILL_JOG_STEP 4'h4
`define KIND_ZERO_CENTRE 4'h5
`define KIND_MOTION 4'h6
`define KIND_RANGE 4'h7
`define KIND_NEG_GROSS 4'h8
`define KIND_NEG_NET 4'h9
`define KIND_BATCH_ACTIVE 4'hA
`define KIND_WATCHDOG 4'hB
`define KIND_CONCUR 4'hC

// Timing
`define CLK_PERIOD_NS 4
`define TICK_TIME_NS 100000000

`endif

// ===== core/batch_setpoint_step_logic.v
// Batch step sequencer, continuous status setpoints, watchdog and concurrent outputs
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "batch_setpoint_defines.vh"
// How it works
// - A delay step holds the sequence for its value in tenths, then advances.
// - A standstill wait step advances only once the scale is still.
// - A repeat step reruns the sequence until its count is done, then ends.
// - A jog step pulses the previous step's output again before advancing.
// - Zero centre kind drives its output from the zero centre flag.
// - Motion kind drives its output while the scale is not still.
// - Range kind drives its output while the reading is within capacity.
// - Negative gross kind drives its output while gross weight is negative.
// - Negative net kind drives its output while net weight is negative.
// - Batch active kind drives its output while a sequence runs.
// - Status kinds never look at the value field.
// - Watchdog value is the longest time in tenths from start to end step.
// - Watchdog output asserts if the end step is not reached in time.
// - Concurrent with value zero holds output from start step to end step.
// - Concurrent with nonzero value holds output from start step for value tenths.
// - Continuous kinds are re-evaluated every scan whatever step is current.
// - A step output is on while its step runs or while a later jog step pulses it, otherwise off.
module batch_setpoint_step_logic #(
  parameter NUM_SP = 20,
  parameter WEIGHT_W = 24,
  parameter TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire scale_still,
  input wire zero_centre_flag,
  input wire capacity_ok_flag,
  input wire [WEIGHT_W-1:0] gross_weight,
  input wire [WEIGHT_W-1:0] net_weight,
  output reg [NUM_SP-1:0] sp_out,
  output reg batch_active_out
);
  localparam [`SP_IDX_W-1:0] LAST_SP = NUM_SP - 1;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // Tenth-second time base
  reg [31:0] tick_div;
  reg [`VAL_W-1:0] tick_now;

  // Register state
  reg auto_mode;
  reg cmd_start;
  reg cmd_abort;

  // Sequencer state
  reg running;
  reg [`SP_IDX_W-1:0] cur_step;
  reg [`SP_IDX_W-1:0] prev_step;
  reg [`VAL_W-1:0] rep_count;
  reg [`VAL_W-1:0] step_time;
  reg jog_on;

  // Per setpoint timer state
  reg [NUM_SP-1:0] fired;
  reg [NUM_SP-1:0] armed;
  reg [NUM_SP-1:0] wd_trip;
  reg [`VAL_W-1:0] t_start [0:NUM_SP-1];

  // Scanner
  reg [`SP_IDX_W-1:0] scan_idx;
  reg [`SP_IDX_W-1:0] scan_q;
  reg scan_valid;

  wire [`CFG_W-1:0] cfg;
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire word_ok = (paddr[1:0] == 2'b00);
  wire cfg_hit = word_ok & (paddr[11:8] == `CFG_PAGE) & (paddr[7:2] < NUM_SP);
  wire reg_hit = word_ok & (paddr[11:8] == 4'h0) & (paddr[7:0] <= `REG_TICK);
  wire hit = cfg_hit | reg_hit;
  wire apb_commit = apb_access & pready & pwrite;
  wire cfg_we = apb_commit & cfg_hit;
  // Bus accesses borrow the table port in setup, so the scan holds that slot a cycle
  wire [`SP_IDX_W-1:0] rd_addr = apb_setup ? paddr[6:2] : scan_idx;

  wire [3:0] kind = cfg[`CFG_KIND_MSB:`CFG_KIND_LSB];
  wire [`VAL_W-1:0] value = cfg[`CFG_VAL_MSB:`CFG_VAL_LSB];
  wire [`SP_IDX_W-1:0] start_sp = cfg[`CFG_START_MSB:`CFG_START_LSB];
  wire [`SP_IDX_W-1:0] end_sp = cfg[`CFG_END_MSB:`CFG_END_LSB];
  wire [`VAL_W-1:0] elapsed_step = tick_now - step_time;
  wire [`VAL_W-1:0] elapsed_sp = tick_now - t_start[scan_q];
  wire [`VAL_W-1:0] jog_len = (value == 16'h0000) ? 16'h0001 : value;
  wire [`VAL_W-1:0] rep_next = rep_count + 16'h0001;
  wire at_step = scan_valid & running & (scan_q == cur_step);
  wire start_hit = ~fired[scan_q] & running & (cur_step == start_sp);

  reg adv;
  reg rep;
  reg jog_now;
  reg run_end;
  reg [31:0] rd_word;

  sp_table #(
    .DEPTH(NUM_SP),
    .AW(`SP_IDX_W),
    .WIDTH(`CFG_W)
  ) u_table (
    .clk(clk),
    .rst(rst),
    .we(cfg_we),
    .waddr(paddr[6:2]),
    .wdata(pwdata[`CFG_W-1:0]),
    .raddr(rd_addr),
    .rdata(cfg)
  );

  always @(posedge clk) begin
    if (rst) begin
      tick_div <= 32'h0000_0000;
      tick_now <= 16'h0000;
    end else if (tick_div >= TICK_LAST) begin
      tick_div <= 32'h0000_0000;
      tick_now <= tick_now + 16'h0001;
    end else begin
      tick_div <= tick_div + 32'h0000_0001;
    end
  end

  // Step decision for the slot of the current step
  always @* begin
    adv = 1'b0;
    rep = 1'b0;
    jog_now = 1'b0;
    run_end = 1'b0;
    if (at_step) begin
      case (kind)
        `KIND_DELAY: begin
          adv = (elapsed_step >= value);
        end
        `KIND_STANDSTILL_WAIT_STEP: begin
          adv = scale_still;
        end
        `KIND_REPEAT: begin
          adv = 1'b1;
          rep = (rep_next < value);
          run_end = ~rep;
        end
        `KIND_FILL_JOG_STEP: begin
          jog_now = 1'b1;
          adv = (elapsed_step >= jog_len);
        end
        default: begin
          // Non-step kinds are passed over at once
          adv = 1'b1;
        end
      endcase
      if (adv & (cur_step == LAST_SP)) begin
        run_end = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      scan_idx <= {`SP_IDX_W{1'b0}};
      scan_q <= {`SP_IDX_W{1'b0}};
      scan_valid <= 1'b0;
    end else begin
      scan_valid <= ~apb_setup;
      scan_q <= scan_idx;
      if (~apb_setup) begin
        scan_idx <= (scan_idx == LAST_SP) ? {`SP_IDX_W{1'b0}} : scan_idx + 1'b1;
      end
    end
  end

  // Per slot evaluation and sequencer
  always @(posedge clk) begin : engine
    integer k;
    if (rst) begin
      running <= 1'b0;
      cur_step <= {`SP_IDX_W{1'b0}};
      prev_step <= {`SP_IDX_W{1'b0}};
      rep_count <= 16'h0000;
      step_time <= 16'h0000;
      jog_on <= 1'b0;
      fired <= {NUM_SP{1'b0}};
      armed <= {NUM_SP{1'b0}};
      wd_trip <= {NUM_SP{1'b0}};
      sp_out <= {NUM_SP{1'b0}};
      batch_active_out <= 1'b0;
      for (k = 0; k < NUM_SP; k = k + 1) begin
        t_start[k] <= 16'h0000;
      end
    end else begin
      batch_active_out <= running;
      if (scan_valid) begin
        // One output bit per setpoint, so concurrent outputs never share a pin
        case (kind)
          `KIND_OFF: sp_out[scan_q] <= 1'b0;
          `KIND_ZERO_CENTRE: sp_out[scan_q] <= zero_centre_flag;
          `KIND_MOTION: sp_out[scan_q] <= ~scale_still;
          `KIND_RANGE: sp_out[scan_q] <= capacity_ok_flag;
          `KIND_NEG_GROSS: sp_out[scan_q] <= gross_weight[WEIGHT_W-1];
          `KIND_NEG_NET: sp_out[scan_q] <= net_weight[WEIGHT_W-1];
          `KIND_BATCH_ACTIVE: sp_out[scan_q] <= running;
          `KIND_WATCHDOG: begin
            if (start_hit) begin
              fired[scan_q] <= 1'b1;
              armed[scan_q] <= 1'b1;
              t_start[scan_q] <= tick_now;
            end else if (armed[scan_q] & (~running | (cur_step == end_sp))) begin
              armed[scan_q] <= 1'b0;
            end else if (armed[scan_q] & (elapsed_sp >= value)) begin
              armed[scan_q] <= 1'b0;
              wd_trip[scan_q] <= 1'b1;
            end
            sp_out[scan_q] <= wd_trip[scan_q];
          end
          `KIND_CONCUR: begin
            if (start_hit) begin
              fired[scan_q] <= 1'b1;
              armed[scan_q] <= 1'b1;
              t_start[scan_q] <= tick_now;
            end else if (armed[scan_q] & ~running) begin
              armed[scan_q] <= 1'b0;
            end else if (armed[scan_q] & (value == 16'h0000) & (cur_step == end_sp)) begin
              armed[scan_q] <= 1'b0;
            end else if (armed[scan_q] & (value != 16'h0000) & (elapsed_sp >= value)) begin
              armed[scan_q] <= 1'b0;
            end
            sp_out[scan_q] <= start_hit | armed[scan_q];
          end
          default: begin
            // Step output: on only while its own step is current or jogged
            sp_out[scan_q] <= running & ((cur_step == scan_q) |
                                          (jog_on & (prev_step == scan_q)));
          end
        endcase
      end

      if (jog_now & ~adv) begin
        jog_on <= 1'b1;
      end else if (adv) begin
        jog_on <= 1'b0;
      end

      if (cmd_abort) begin
        running <= 1'b0;
        jog_on <= 1'b0;
      end else if (cmd_start & ~running) begin
        running <= 1'b1;
        cur_step <= {`SP_IDX_W{1'b0}};
        rep_count <= 16'h0000;
        step_time <= tick_now;
        fired <= {NUM_SP{1'b0}};
        wd_trip <= {NUM_SP{1'b0}};
      end else if (adv) begin
        step_time <= tick_now;
        if (kind != `KIND_FILL_JOG_STEP) begin
          prev_step <= cur_step;
        end
        if (rep) begin
          rep_count <= rep_next;
          cur_step <= {`SP_IDX_W{1'b0}};
          fired <= {NUM_SP{1'b0}};
        end else if (run_end) begin
          rep_count <= 16'h0000;
          cur_step <= {`SP_IDX_W{1'b0}};
          fired <= {NUM_SP{1'b0}};
          // Auto mode reruns forever; otherwise wait for a new start
          running <= auto_mode;
        end else begin
          cur_step <= cur_step + 1'b1;
        end
      end
    end
  end

  // Read mux
  always @* begin
    rd_word = 32'h0000_0000;
    if (cfg_hit) begin
      rd_word[`CFG_W-1:0] = cfg;
    end else begin
      case (paddr)
        `REG_CTRL: rd_word[`CTRL_AUTO_BIT] = auto_mode;
        `REG_STATUS: begin
          rd_word[`ST_RUN_BIT] = running;
          rd_word[`ST_STEP_MSB:`ST_STEP_LSB] = cur_step;
          rd_word[`ST_REP_MSB:`ST_REP_LSB] = rep_count;
        end
        `REG_OUTS: rd_word[NUM_SP-1:0] = sp_out;
        `REG_TICK: rd_word[`VAL_W-1:0] = tick_now;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // APB slave: one wait state, read data is registered as pready rises, the write lands on the next edge
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      auto_mode <= `CTRL_RESET;
      cmd_start <= 1'b0;
      cmd_abort <= 1'b0;
    end else begin
      cmd_start <= 1'b0;
      cmd_abort <= 1'b0;
      if (apb_access & ~pready) begin
        pready <= 1'b1;
        pslverr <= ~hit;
        prdata <= (pwrite | ~hit) ? 32'h0000_0000 : rd_word;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      if (apb_commit & reg_hit) begin
        case (paddr)
          `REG_CTRL: auto_mode <= pwdata[`CTRL_AUTO_BIT];
          `REG_CMD: begin
            cmd_start <= pwdata[`CMD_START_BIT];
            cmd_abort <= pwdata[`CMD_ABORT_BIT];
          end
          default: auto_mode <= auto_mode;
        endcase
      end
    end
  end
endmodule // batch_setpoint_step_logic

// ===== core/sp_table.v
// Setpoint configuration table with one write port and a registered read port
`timescale 1ns/10ps
module sp_table #(
  parameter DEPTH = 20,
  parameter AW = 5,
  parameter WIDTH = 30
) (
  input wire clk,
  input wire rst,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  // Cleared on reset so every kind starts as off
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
      rdata <= {WIDTH{1'b0}};
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // sp_table

// ===== test/batch_setpoint_step_logic_props.sv
// Port checker for the batch setpoint logic
`timescale 1ns/10ps
module batch_setpoint_step_logic_props #(
  parameter NUM_SP = 20,
  parameter WEIGHT_W = 24
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scale_still,
  input wire zero_centre_flag,
  input wire capacity_ok_flag,
  input wire [WEIGHT_W-1:0] gross_weight,
  input wire [WEIGHT_W-1:0] net_weight,
  input wire [NUM_SP-1:0] sp_out,
  input wire batch_active_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_clear: assert property (disable iff (1'b0) rst |=> sp_out == 0 && !batch_active_out)
    else $error("outputs not cleared by reset");
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_idle: assert property (!psel |-> !pready)
    else $error("ready without select");
  a_err_page: assert property (psel && penable && pready && paddr[11:8] > 4'h1 |-> pslverr)
    else $error("bad page accepted");
  a_err_index: assert property (pready && paddr[11:8] == 4'h1 && paddr[7:2] >= NUM_SP |-> pslverr)
    else $error("bad index accepted");
  a_ok_map: assert property (pready && paddr[11:8] == 0 && paddr[1:0] == 0 && paddr[7:0] <= 8'h10
    |-> !pslverr) else $error("mapped register refused");
  a_err_data: assert property (pslverr |-> pready && prdata == 0)
    else $error("error response malformed");
  a_write_zero: assert property (pready && pwrite |-> prdata == 0)
    else $error("write returned data");
  a_run_match: assert property (pready && !pwrite && !pslverr && paddr == 12'h008
    |-> prdata[0] == batch_active_out) else $error("status run bit and batch output differ");
  a_outs_match: assert property (pready && !pwrite && !pslverr && paddr == 12'h00C
    |-> prdata[NUM_SP-1:0] == $past(sp_out)) else $error("output register differs from pins");
endmodule // batch_setpoint_step_logic_props
bind batch_setpoint_step_logic batch_setpoint_step_logic_props #(.NUM_SP(NUM_SP),
  .WEIGHT_W(WEIGHT_W)) u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scale_still(scale_still), .zero_centre_flag(zero_centre_flag),
  .capacity_ok_flag(capacity_ok_flag), .gross_weight(gross_weight), .net_weight(net_weight),
  .sp_out(sp_out), .batch_active_out(batch_active_out));

// ===== test/batch_setpoint_step_logic_tb_top.sv
// Testbench for the batch setpoint logic
`timescale 1ns/10ps
`include "batch_setpoint_defines.vh"
module batch_setpoint_step_logic_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, rerr, still, zero, cap, batch_active_out;
  logic [23:0] gross, net;
  logic [19:0] sp_out;
  logic [4:0] pat = 5'h00;
  int num_errors = 0, checks = 0;
  always #2 clk = ~clk;
  scale_front_model #(.W(24)) model (.clk(clk), .pat(pat), .still(still), .zero(zero),
    .cap(cap), .gross(gross), .net(net));
  batch_setpoint_step_logic #(.NUM_SP(20), .WEIGHT_W(24), .TICK_CYCLES(4)) dut (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scale_still(still), .zero_centre_flag(zero), .capacity_ok_flag(cap),
    .gross_weight(gross), .net_weight(net), .sp_out(sp_out),
    .batch_active_out(batch_active_out));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      tally_and_finish;
    end
    rdat = prdata; rerr = pslverr; psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a);
    apb(0, a, 0);
  endtask
  function logic [11:0] cadr(input int i);
    return 12'(12'h100 + 4 * i);
  endfunction
  function logic [31:0] cfg(input logic [3:0] k, input logic [15:0] v, input logic [4:0] s,
    input logic [4:0] e);
    return {2'b00, e, s, v, k};
  endfunction
  task poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(`REG_STATUS);
      if ((rdat & m) === v) return;
    end
    num_errors++;
    tally_and_finish;
  endtask
  task test_reset;
    rd(`REG_STATUS); chk(rdat, 0);
    rd(cadr(3)); chk(rdat, 0);
    apb(1, `REG_CTRL, 1); rd(`REG_CTRL); chk(rdat, 1);
    apb(1, `REG_CTRL, 0);
    rd(12'h200); chk(rerr, 1);
    rd(cadr(20)); chk(rerr, 1);
    rd(12'h006); chk(rerr, 1);
    $display("test_reset done");
  endtask
  task test_status;
    static logic [4:0] p[4] = '{5'h15, 5'h0A, 5'h1F, 5'h00};
    // Nonzero value on every status kind: it must make no difference
    for (int i = 0; i < 6; i++) apb(1, cadr(i), cfg(4'(5 + i), 16'hABCD, 0, 0));
    for (int i = 0; i < 4; i++) begin
      pat <= p[i];
      repeat (60) @(posedge clk);
      rd(`REG_OUTS);
      chk(rdat[5:0], {1'b0, p[i][4:2], ~p[i][1], p[i][0]});
      chk(sp_out[5:0], {1'b0, p[i][4:2], ~p[i][1], p[i][0]});
    end
    $display("test_status done");
  endtask
  task test_batch;
    // Distinct outputs for the two concurrent setpoints
    apb(1, cadr(6), cfg(`KIND_DELAY, 50, 0, 0));
    apb(1, cadr(7), cfg(`KIND_STANDSTILL_WAIT_STEP, 0, 0, 0));
    apb(1, cadr(8), cfg(`KIND_REPEAT, 2, 0, 0));
    apb(1, cadr(9), cfg(`KIND_CONCUR, 0, 6, 8));
    apb(1, cadr(10), cfg(`KIND_WATCHDOG, 2, 7, 8));
    apb(1, cadr(11), cfg(`KIND_CONCUR, 30, 6, 0));
    pat <= 5'h00;
    apb(1, `REG_CMD, 1);
    repeat (60) @(posedge clk);
    rd(`REG_STATUS); chk(rdat & 32'h1F01, 32'h0601);
    rd(`REG_OUTS); chk(rdat[11:5], 7'b1010011);
    chk(batch_active_out, 1);
    chk(sp_out[11:5], 7'b1010011);
    poll(32'h1F01, 32'h0701);
    repeat (100) @(posedge clk);
    rd(`REG_STATUS); chk(rdat & 32'h1F01, 32'h0701);
    rd(`REG_OUTS); chk(rdat[11:5], 7'b0110101);
    pat <= 5'h02;
    poll(32'h1F01, 32'h0601);
    poll(32'h1, 0);
    // Outputs follow at scan rate, so let the scanner make a full pass
    repeat (30) @(posedge clk);
    rd(`REG_OUTS); chk(rdat & 32'h0BE0, 0);
    chk(sp_out[11:5] & 7'h5F, 0);
    chk(batch_active_out, 0);
    $display("test_batch done");
  endtask
  task test_abort;
    apb(1, `REG_CMD, 1);
    poll(32'h1F01, 32'h0601);
    apb(1, `REG_CMD, 2);
    rd(`REG_STATUS); chk(rdat[0], 0);
    chk(batch_active_out, 0);
    $display("test_abort done");
  endtask
  task test_jog;
    // Jog after the delay step; auto mode must restart the run
    apb(1, cadr(7), cfg(`KIND_FILL_JOG_STEP, 20, 0, 0));
    apb(1, cadr(8), 0);
    apb(1, `REG_CTRL, 1);
    apb(1, `REG_CMD, 1);
    poll(32'h1F01, 32'h0701);
    // Jog lasts 80 cycles; the delay step output needs one scan to return
    repeat (40) @(posedge clk);
    chk(sp_out[7:6], 2'b11);
    poll(32'h1F01, 32'h0601);
    chk(batch_active_out, 1);
    apb(1, `REG_CMD, 2);
    apb(1, `REG_CTRL, 0);
    repeat (30) @(posedge clk);
    chk(sp_out[7:5], 0);
    $display("test_jog done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    test_reset;
    test_status;
    test_batch;
    test_abort;
    test_jog;
    tally_and_finish;
  end
endmodule // batch_setpoint_step_logic_tb_top

// ===== test/scale_front_model.sv
// Scale status front end model
`timescale 1ns/10ps
module scale_front_model #(
  parameter W = 24
) (
  input wire clk,
  input wire [4:0] pat,
  output reg still,
  output reg zero,
  output reg cap,
  output reg [W-1:0] gross,
  output reg [W-1:0] net
);
  reg [7:0] cnt = 8'h00;
  // Weights wander each cycle so only the sign carries meaning
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    zero <= pat[0];
    still <= pat[1];
    cap <= pat[2];
    gross <= pat[3] ? -W'(cnt) - W'(1) : W'(cnt);
    net <= pat[4] ? -W'(cnt) - W'(2) : W'(cnt);
  end
endmodule // scale_front_model
